//--- hdl/comparator_control.sv
// Purpose: control and status logic around one analog comparator
// Assumes: apb slave, comparator output synchronous to sys_clk
// Notes: analog switches are steered by the select outputs
//
// Summary of operation
// [R01] enable bit 15 switches comparator on, other fields untouched
// [R02] clearing enable powers comparator down, other fields kept
// [R03] output-pin enable bit 14 drives result onto the output pin
// [R04] invert bit 13 inverts the result before presenting it
// [R05] read-only bit 8 shows the current comparator result
// [R06] edge select 7:6: 11 both, 10 falling, 01 rising, 00 off
// [R07] inversion also applies to the edge detector input
// [R08] plus select bit 4: 1 internal ladder reference, 0 pin A
// [R09] minus select 1:0: 11 band ref, 10 D, 01 C, 00 B
// [R10] unimplemented control bits ignore writes and read zero
// [R11] software avoids access the cycle after clearing enable
// [R12] result sampled each clock, edges found by compare, one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module comparator_control
    import comparator_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic analogResult,
    output logic comparatorEnable,
    output logic plusSelectLadder,
    output logic [3:0] minusSelect,
    output logic comparePinOut,
    output logic comparePinOe,
    output logic irq
);
    // ****************************************
    // registers
    // ****************************************
    logic [31:0] control;
    logic irqStatus;
    logic irqMask;
    logic result;
    logic setupPhase;
    logic accessWrite;
    logic eventPulse;
    edge_event_if ev ();

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction : hit

    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit(paddr, CONTROL_OFFSET)
        & ~hit(paddr, IRQ_STATUS_OFFSET) & ~hit(paddr, IRQ_MASK_OFFSET);

    // [R01] [R02] [R10] masked write keeps unimplemented bits zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control <= CONTROL_RESET;
        end else if (accessWrite && hit(paddr, CONTROL_OFFSET)) begin
            control <= pwdata & CONTROL_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqMask <= 1'b0;
        end else if (accessWrite && hit(paddr, IRQ_MASK_OFFSET)) begin
            irqMask <= pwdata[0];
        end
    end

    // ****************************************
    // result path
    // ****************************************
    // [R04] [R12] sampled and optionally inverted; off reads zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result <= 1'b0;
        end else begin
            result <= control[ENABLE_BIT]
                & (analogResult ^ control[INVERT_BIT]);
        end
    end

    // [R07] detector sees the inverted result
    assign ev.level = result;
    assign ev.edgeSelect = control[EDGE_SEL_LSB +: 2];
    assign eventPulse = ev.eventPulse;

    comparator_edge_detect u_edge (
        .sys_clk(sys_clk),
        .rst(rst),
        .ev(ev)
    );

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqStatus <= 1'b0;
        end else if (eventPulse) begin
            irqStatus <= 1'b1;
        end else if (accessWrite && hit(paddr, IRQ_STATUS_OFFSET)
                     && pwdata[0]) begin
            irqStatus <= 1'b0;
        end
    end

    assign irq = irqStatus & irqMask;

    // ****************************************
    // analog steering and pin
    // ****************************************
    // [R01] [R02] power control
    assign comparatorEnable = control[ENABLE_BIT];
    // [R08] positive input route
    assign plusSelectLadder = control[PLUS_SEL_BIT];

    // [R09] one-hot minus input route
    always_comb begin
        case (control[MINUS_SEL_LSB +: 2])
            MINUS_PIN_B: minusSelect = 4'h1;
            MINUS_PIN_C: minusSelect = 4'h2;
            MINUS_PIN_D: minusSelect = 4'h4;
            MINUS_BAND: minusSelect = 4'h8;
            default: minusSelect = 4'h1;
        endcase
    end

    // [R03] pin driven whenever bit 14 is set; value reads zero while enable bit 15 is clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            comparePinOut <= 1'b0;
            comparePinOe <= 1'b0;
        end else begin
            comparePinOut <= control[ENABLE_BIT]
                & (analogResult ^ control[INVERT_BIT]);
            comparePinOe <= control[PIN_ENABLE_BIT];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // [R05] [R10] result bit merged into control readback
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            if (hit(paddr, CONTROL_OFFSET)) begin
                prdata <= control | ({31'h0000_0000, result} << RESULT_BIT);
            end else if (hit(paddr, IRQ_STATUS_OFFSET)) begin
                prdata <= {31'h0000_0000, irqStatus};
            end else if (hit(paddr, IRQ_MASK_OFFSET)) begin
                prdata <= {31'h0000_0000, irqMask};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (control & ~CONTROL_WRITE_MASK) == 32'h0000_0000) // [R10]
        else $error("unimplemented control bit set");

    a_pin_enable: assert property (@(posedge sys_clk) disable iff (rst)
        comparePinOe == $past(control[PIN_ENABLE_BIT])) // [R03]
        else $error("pin enable does not follow control");

    a_invert_path: assert property (@(posedge sys_clk) disable iff (rst)
        $past(control[ENABLE_BIT]) |->
        result == ($past(analogResult) ^ $past(control[INVERT_BIT]))) // [R04]
        else $error("result inversion wrong");

    a_off_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(control[ENABLE_BIT]) |->
        control[14:0] == ($past(pwdata[14:0]) & CONTROL_WRITE_MASK[14:0])) // [R02]
        else $error("fields lost on disable");

    a_on_enable: assert property (@(posedge sys_clk) disable iff (rst)
        accessWrite && hit(paddr, CONTROL_OFFSET) && pwdata[ENABLE_BIT]
        |=> comparatorEnable) // [R01]
        else $error("enable not applied");

    a_minus_route: assert property (@(posedge sys_clk) disable iff (rst)
        control[1:0] == MINUS_BAND |-> minusSelect == 4'h8) // [R09]
        else $error("band reference not routed");

    a_event_sets: assert property (@(posedge sys_clk) disable iff (rst)
        eventPulse |=> irqStatus && (!irqMask || irq)) // [R12]
        else $error("event lost");

    // ****************************************
    // further checks on steering, pin, interrupt and bus
    // ****************************************
    // a powered-down comparator must never report a high result
    a_result_off: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(control[ENABLE_BIT]) |-> !result) // [R02]
        else $error("result high while disabled");

    a_pin_value: assert property (@(posedge sys_clk) disable iff (rst)
        comparePinOut == ($past(control[ENABLE_BIT])
        & ($past(analogResult) ^ $past(control[INVERT_BIT])))) // [R03]
        else $error("pin value wrong");

    a_enable_out: assert property (@(posedge sys_clk) disable iff (rst)
        comparatorEnable == control[ENABLE_BIT]) // [R01]
        else $error("enable output does not follow control");

    a_plus_route: assert property (@(posedge sys_clk) disable iff (rst)
        plusSelectLadder == control[PLUS_SEL_BIT]) // [R08]
        else $error("plus input route wrong");

    a_minus_pinb: assert property (@(posedge sys_clk) disable iff (rst)
        control[1:0] == MINUS_PIN_B |-> minusSelect == 4'h1) // [R09]
        else $error("pin b not routed");

    a_minus_pinc: assert property (@(posedge sys_clk) disable iff (rst)
        control[1:0] == MINUS_PIN_C |-> minusSelect == 4'h2) // [R09]
        else $error("pin c not routed");

    a_minus_pind: assert property (@(posedge sys_clk) disable iff (rst)
        control[1:0] == MINUS_PIN_D |-> minusSelect == 4'h4) // [R09]
        else $error("pin d not routed");

    // two switches closed at once would short two inputs together
    a_minus_onehot: assert property (@(posedge sys_clk) disable iff (rst)
        $onehot(minusSelect)) // [R09]
        else $error("minus route not one-hot");

    a_status_clear: assert property (@(posedge sys_clk) disable iff (rst)
        accessWrite && hit(paddr, IRQ_STATUS_OFFSET) && pwdata[0]
        && !eventPulse |=> !irqStatus) // [R12]
        else $error("status not cleared");

    a_irq_masked: assert property (@(posedge sys_clk) disable iff (rst)
        !irqMask |-> !irq) // [R12]
        else $error("masked interrupt raised");

    a_read_upper: assert property (@(posedge sys_clk) disable iff (rst)
        setupPhase && !pwrite && hit(paddr, CONTROL_OFFSET)
        |=> prdata[31:16] == 16'h0000) // [R10]
        else $error("upper control bits read nonzero");

    a_read_gaps: assert property (@(posedge sys_clk) disable iff (rst)
        setupPhase && !pwrite && hit(paddr, CONTROL_OFFSET)
        |=> prdata[12:9] == 4'h0 && !prdata[5] && prdata[3:2] == 2'h0) // [R10]
        else $error("unimplemented control bits read nonzero");

    a_pin_oe_off: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(control[PIN_ENABLE_BIT]) |-> !comparePinOe) // [R03]
        else $error("pin driven while disabled");

    a_read_result: assert property (@(posedge sys_clk) disable iff (rst)
        setupPhase && !pwrite && hit(paddr, CONTROL_OFFSET)
        |=> prdata[RESULT_BIT] == $past(result)) // [R05]
        else $error("result bit read wrong");
endmodule : comparator_control
`default_nettype wire

//--- hdl/comparator_pkg.sv
// Purpose: constants and types shared by the comparator control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets of all registers are local choices
package comparator_pkg;
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
    localparam int ENABLE_BIT = 15;
    localparam int PIN_ENABLE_BIT = 14;
    localparam int INVERT_BIT = 13;
    localparam int RESULT_BIT = 8;
    localparam int EDGE_SEL_LSB = 6;
    localparam int PLUS_SEL_BIT = 4;
    localparam int MINUS_SEL_LSB = 0;
    // writable bits: 15..13, 7..6, 4, 1..0
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_e0d3;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_00c3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] MINUS_PIN_B = 2'h0;
    localparam logic [1:0] MINUS_PIN_C = 2'h1;
    localparam logic [1:0] MINUS_PIN_D = 2'h2;
    localparam logic [1:0] MINUS_BAND = 2'h3;
    typedef enum {ST_IDLE, ST_ACCESS} apb_state_t;
endpackage : comparator_pkg

//--- hdl/edge_event_if.sv
// Purpose: carries sampled result and edge select to the edge detector
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface edge_event_if;
    logic level;
    logic [1:0] edgeSelect;
    logic eventPulse;
    modport control (output level, output edgeSelect, input eventPulse);
    modport detector (input level, input edgeSelect, output eventPulse);
endinterface : edge_event_if
`default_nettype wire

//--- hdl/comparator_edge_detect.sv
// Purpose: edge detector that raises a one-cycle event on a chosen edge
// Assumes: level is already synchronous to sys_clk
// Notes: previous sample held in one flip-flop
`timescale 1ns/1ns
`default_nettype none
module comparator_edge_detect
    import comparator_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    edge_event_if.detector ev
);
    logic prevLevel;
    logic pulse;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prevLevel <= 1'b0;
        end else begin
            prevLevel <= ev.level;
        end
    end

    // [R06] edge select decode
    always_comb begin
        case (ev.edgeSelect)
            EDGE_RISE: pulse = ev.level & ~prevLevel;
            EDGE_FALL: pulse = ~ev.level & prevLevel;
            EDGE_BOTH: pulse = ev.level ^ prevLevel;
            default: pulse = 1'b0;
        endcase
    end

    // [R12] one-cycle request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ev.eventPulse <= 1'b0;
        end else begin
            ev.eventPulse <= pulse;
        end
    end

    // [R12] pulse lasts one cycle unless the level keeps toggling
    a_pulse_single: assert property (@(posedge sys_clk) disable iff (rst)
        ev.eventPulse && $stable(ev.level) |=> !ev.eventPulse) // [R12]
        else $error("event pulse longer than one cycle");

    a_rise_only: assert property (@(posedge sys_clk) disable iff (rst)
        ev.edgeSelect == EDGE_RISE && $fell(ev.level)
        && $stable(ev.edgeSelect) |=> !ev.eventPulse) // [R06]
        else $error("rising select fired on falling edge");

    a_fall_only: assert property (@(posedge sys_clk) disable iff (rst)
        ev.edgeSelect == EDGE_FALL && $rose(ev.level)
        && $stable(ev.edgeSelect) |=> !ev.eventPulse) // [R06]
        else $error("falling select fired on rising edge");

    a_none_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        ev.edgeSelect == EDGE_NONE |=> !ev.eventPulse) // [R06]
        else $error("event raised while disabled");
endmodule : comparator_edge_detect
`default_nettype wire

//--- tb/comparator_analog_model.sv
// Purpose: behavioural analog comparator facing the control block
// Assumes: each input level is an unsigned 8-bit code
// Notes: volts index 0 pin a, 1..3 pins b..d, 4 ladder, 5 band
`timescale 1ns/1ns
`default_nettype none
module comparator_analog_model (
    input wire logic sys_clk,
    input wire logic [5:0][7:0] volts,
    input wire logic comparatorEnable,
    input wire logic plusSelectLadder,
    input wire logic [3:0] minusSelect,
    output logic analogResult
);
    // ********
    // analog path
    // ********
    logic [7:0] plusLevel;
    logic [7:0] minusLevel;
    logic wander = 1'b0;
    assign plusLevel = plusSelectLadder ? volts[4] : volts[0];
    assign minusLevel = minusSelect[0] ? volts[1] : minusSelect[1] ?
        volts[2] : minusSelect[2] ? volts[3] : volts[5];
    always_ff @(posedge sys_clk) begin
        wander <= ~wander;
    end
    // powered down
    // output means nothing when off, so it wanders rather than hold
    always_ff @(posedge sys_clk) begin
        analogResult <= comparatorEnable ? plusLevel > minusLevel : wander;
    end
endmodule : comparator_analog_model
`default_nettype wire

//--- tb/comparator_control_tb.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: zero-wait apb slave, irq status at 0x004, mask at 0x008
// Notes: waits after input changes cover the four-edge event path
`timescale 1ns/1ns
`default_nettype none
module comparator_control_tb
    import comparator_pkg::*;
;
    // ********
    // signals and helpers
    // ********
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic analogResult, comparatorEnable, plusSelectLadder, rdErr;
    logic [3:0] minusSelect;
    logic comparePinOut, comparePinOe;
    logic [5:0][7:0] volts;
    int failures, compares, cycles;
    comparator_control DUT (.sys_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .analogResult,
        .comparatorEnable, .plusSelectLadder, .minusSelect,
        .comparePinOut, .comparePinOe, .irq);
    comparator_analog_model partner (.sys_clk, .volts, .comparatorEnable,
        .plusSelectLadder, .minusSelect, .analogResult);
    task stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // access spacing
    // every transfer is followed by an idle cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ********
    // scenarios
    // ********
    task t_fields;
        apb(0, CONTROL_OFFSET, 0);
        chk("reset", CONTROL_RESET, rd);
        chk("minus", 4'h8, minusSelect);
        apb(1, CONTROL_OFFSET, 32'hffff_ffff);
        apb(0, CONTROL_OFFSET, 0);
        chk("ones", CONTROL_WRITE_MASK, rd & ~32'h100);
        chk("on", 1, comparatorEnable);
        apb(1, CONTROL_OFFSET, 32'h0000_60d3);
        apb(0, CONTROL_OFFSET, 0);
        chk("kept", 32'h0000_60d3, rd);
        chk("off", 0, comparatorEnable);
        apb(0, 12'h00c, 0);
        chk("unmapped", 1, rdErr);
        $display("done fields");
    endtask : t_fields
    task t_route;
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                apb(1, CONTROL_OFFSET, 32'h8000 | p << 4 | m);
                tick(3);
                apb(0, CONTROL_OFFSET, 0);
                chk("plus", p, plusSelectLadder);
                chk("minus", 1 << m, minusSelect);
                chk("result", 8'hb1 >> (p * 4 + m) & 1, rd[8]);
            end
        end
        $display("done route");
    endtask : t_route
    task t_pin;
        volts[0] <= 8'hff;
        for (int i = 0; i < 2; i++) begin
            for (int o = 0; o < 2; o++) begin
                apb(1, CONTROL_OFFSET, 32'h8000 | o << 14 | i << 13);
                tick(3);
                apb(0, CONTROL_OFFSET, 0);
                chk("result", !i, rd[8]);
                chk("oe", o, comparePinOe);
                if (o == 1) chk("pin", !i, comparePinOut);
            end
        end
        $display("done pin");
    endtask : t_pin
    task edge_step(input logic [7:0] v, input logic e);
        volts[0] <= v;
        tick(6);
        apb(0, IRQ_STATUS_OFFSET, 0);
        chk("status", e, rd[0]);
        chk("irq", e, irq);
        apb(1, IRQ_STATUS_OFFSET, 1);
        // the clear lands on the access edge; look once it has settled
        tick(1);
        chk("cleared", 0, irq);
    endtask : edge_step
    task t_edges;
        logic [1:0] c;
        apb(1, IRQ_MASK_OFFSET, 1);
        for (int k = 0; k < 8; k++) begin
            c = k[2:1];
            volts[0] <= 8'h00;
            apb(1, CONTROL_OFFSET, 32'h8000 | k[0] << 13 | c << 6);
            tick(5);
            apb(1, IRQ_STATUS_OFFSET, 1);
            edge_step(8'hff, k[0] ? c[1] : c[0]);
            edge_step(8'h00, k[0] ? c[0] : c[1]);
        end
        apb(1, IRQ_MASK_OFFSET, 0);
        volts[0] <= 8'hff;
        tick(6);
        apb(0, IRQ_STATUS_OFFSET, 0);
        chk("masked status", 1, rd[0]);
        chk("masked irq", 0, irq);
        $display("done edges");
    endtask : t_edges
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        cycles = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        volts = {8'h78, 8'hc8, 8'hfa, 8'h96, 8'h32, 8'h64};
        tick(6);
        rst <= 1'b0;
        t_fields();
        t_route();
        t_pin();
        t_edges();
        stop_test();
    end
endmodule : comparator_control_tb
`default_nettype wire
